//--- hw/scpm_top.sv
// Strap capture, host bus pin roles and panel pin multiplexing
`default_nettype none
`include "scpm_map.svh"
module scpm_top (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // Straps
  input wire logic power_polarity_strap_in,
  input wire logic byte_order_strap_in,
  input wire logic [2:0] bus_select_straps_in,
  input wire logic bus_start_input_in,
  // Host bus pins after the mode decode
  input wire scpm_pkg::scpm_hostpins_t host_pins_in,
  output scpm_pkg::scpm_strobes_t host_strobes_out,
  output logic [15:0] host_data_out,
  // Display engine side
  input wire logic panel_power_on_in,
  input wire logic frame_pulse_in,
  input wire logic line_pulse_in,
  input wire logic shift_clock_in,
  input wire logic second_shift_clock_in,
  input wire logic backplane_bias_in,
  input wire logic display_enable_in,
  input wire logic [11:0] pixel_data_in,
  output logic video_invert_out,
  // Panel pins
  output logic panel_power_control_out,
  output logic frame_pulse_out,
  output logic line_pulse_out,
  output logic shift_clock_out,
  output logic display_enable_pin_out,
  output logic [7:0] panel_data_out,
  output logic [3:0] panel_data_hi_out,
  input wire logic [3:0] panel_data_hi_in,
  output logic [3:0] panel_data_hi_oe_n_out,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o
);
  // ****************************************
  // Strap capture
  // ****************************************
  scpm_pkg::scpm_cfg_t cfg;
  logic cfg_valid;
  scpm_strap_latch u_strap (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .power_polarity_strap_in(power_polarity_strap_in),
    .byte_order_strap_in(byte_order_strap_in),
    .bus_select_straps_in(bus_select_straps_in),
    .bus_start_input_in(bus_start_input_in),
    .cfg_out(cfg),
    .cfg_valid_out(cfg_valid)
  );
  // ****************************************
  // Host bus decode
  // ****************************************
  scpm_pkg::scpm_hostpins_t host_s1;
  scpm_pkg::scpm_hostpins_t host_s2;
  // Host pins come from another clock; two flops before any logic reads them.
  // The bus holds its levels through a strobe, so per-bit sync costs only latency.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      host_s1 <= '1;
      host_s2 <= '1;
    end else begin
      host_s1 <= host_pins_in;
      host_s2 <= host_s1;
    end
  end
  scpm_pkg::scpm_strobes_t strobes;
  scpm_host_decode u_host (
    .host_in(cfg.host),
    .pins_in(host_s2),
    .strobes_out(strobes)
  );
  // Strobes only count once the mode is known
  assign host_strobes_out = cfg_valid ? strobes : '0;
  // Byte order swap for the host data path
  function automatic logic [15:0] scpm_swap(input logic [15:0] d, input logic big);
    scpm_swap = big ? {d[7:0], d[15:8]} : d;
  endfunction
  // ****************************************
  // Registers
  // ****************************************
  logic [3:0] panel_type;
  logic [7:0] panel_ctl;
  logic [3:0] gpio_dir;
  logic [3:0] gpio_out;
  logic [3:0] gpio_s1;
  logic [3:0] gpio_s2;
  logic [15:0] data_q;
  logic ack;
  logic [31:0] rdata;
  // Address decode
  wire logic req = wb_cyc_i && wb_stb_i && !ack;
  wire logic hit_strap = wb_adr_i == `SCPM_OFF_STRAP;
  wire logic hit_panel = wb_adr_i == `SCPM_OFF_PANEL;
  wire logic hit_dir = wb_adr_i == `SCPM_OFF_GPIO_DIR;
  wire logic hit_out = wb_adr_i == `SCPM_OFF_GPIO_OUT;
  wire logic hit_in = wb_adr_i == `SCPM_OFF_GPIO_IN;
  wire logic hit_ctl = wb_adr_i == `SCPM_OFF_PANEL_CTL;
  wire logic hit_any = hit_strap || hit_panel || hit_dir || hit_out || hit_in || hit_ctl;
  wire logic wr_lane0 = req && wb_we_i && wb_sel_i[0];
  // Read mux; strap register shows the caught settings
  wire logic [31:0] next_rdata =
    hit_strap ? {26'h0, cfg.power_high, cfg.big_endian, cfg.host, cfg_valid} :
    hit_panel ? {28'h0, panel_type} :
    hit_dir ? {28'h0, gpio_dir} :
    hit_out ? {28'h0, gpio_out} :
    hit_in ? {28'h0, gpio_s2} :
    hit_ctl ? {24'h0, panel_ctl} : 32'h0;
  // One-cycle ack for mapped offsets, err otherwise
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack <= 1'b0;
      wb_err_o <= 1'b0;
      rdata <= 32'h0;
    end else begin
      ack <= req && hit_any;
      wb_err_o <= req && !hit_any && !wb_err_o;
      rdata <= next_rdata;
    end
  end
  assign wb_ack_o = ack;
  assign wb_dat_o = rdata;
  // Writable control registers
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      panel_type <= `SCPM_PANEL_RESET;
      panel_ctl <= `SCPM_PANEL_CTL_RESET;
      gpio_dir <= `SCPM_GPIO_RESET;
      gpio_out <= `SCPM_GPIO_RESET;
    end else if (wr_lane0) begin
      if (hit_panel && wb_dat_i[3:0] <= 4'h8) panel_type <= wb_dat_i[3:0];
      if (hit_ctl) panel_ctl <= wb_dat_i[7:0];
      if (hit_dir) gpio_dir <= wb_dat_i[3:0];
      if (hit_out) gpio_out <= wb_dat_i[3:0];
    end
  end
  // GPIO input synchroniser; pins are asynchronous
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gpio_s1 <= 4'h0;
      gpio_s2 <= 4'h0;
    end else begin
      gpio_s1 <= panel_data_hi_in;
      gpio_s2 <= gpio_s1;
    end
  end
  // ****************************************
  // Panel pin multiplexing
  // ****************************************
  wire scpm_pkg::scpm_panel_t ptype = scpm_pkg::scpm_panel_t'(panel_type);
  wire logic is_tft = ptype == scpm_pkg::SCPM_PNL_TFT9 || ptype == scpm_pkg::SCPM_PNL_TFT12;
  wire logic is_tft12 = ptype == scpm_pkg::SCPM_PNL_TFT12;
  wire logic is_nib = ptype == scpm_pkg::SCPM_PNL_MONO4 || ptype == scpm_pkg::SCPM_PNL_COL4;
  wire logic is_dual = ptype == scpm_pkg::SCPM_PNL_MONO8D || ptype == scpm_pkg::SCPM_PNL_COL8D;
  wire logic inv_en = panel_ctl[`SCPM_INVERT_BIT] && !is_tft12;
  // Display-enable pin role by panel
  wire logic next_enable_pin = is_tft ? display_enable_in :
    (ptype == scpm_pkg::SCPM_PNL_COL8F1) ? second_shift_clock_in : backplane_bias_in;
  // Low byte: nibble panels zero bits 3:0; dual puts lower half low
  wire logic [7:0] next_pdata = is_nib ? {pixel_data_in[3:0], 4'h0} :
    is_dual ? {pixel_data_in[7:4], pixel_data_in[3:0]} : pixel_data_in[7:0];
  // Upper four: TFT data (bit 8 only on 9-bit, bits 8-11 on 12-bit) else GPIO
  wire logic [3:0] tft_mask = is_tft12 ? 4'hF : (is_tft ? 4'h1 : 4'h0);
  wire logic [3:0] gpio_drive = gpio_dir & ~tft_mask & {!inv_en, 3'h7};
  wire logic [3:0] next_hi = (tft_mask & pixel_data_in[11:8]) | (~tft_mask & gpio_out);
  // Registered panel outputs; power level follows the strap
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      panel_power_control_out <= 1'b0;
      frame_pulse_out <= 1'b0;
      line_pulse_out <= 1'b0;
      shift_clock_out <= 1'b0;
      display_enable_pin_out <= 1'b0;
      panel_data_out <= 8'h00;
      panel_data_hi_out <= 4'h0;
      panel_data_hi_oe_n_out <= 4'hF;
      video_invert_out <= 1'b0;
      data_q <= 16'h0000;
    end else begin
      panel_power_control_out <= cfg_valid ? (panel_power_on_in == cfg.power_high) : 1'b0;
      frame_pulse_out <= frame_pulse_in;
      line_pulse_out <= line_pulse_in;
      shift_clock_out <= shift_clock_in;
      display_enable_pin_out <= next_enable_pin;
      panel_data_out <= next_pdata;
      panel_data_hi_out <= next_hi;
      panel_data_hi_oe_n_out <= ~(tft_mask | gpio_drive);
      video_invert_out <= inv_en && !gpio_s2[3];
      data_q <= scpm_swap(host_s2.data, cfg.big_endian);
    end
  end
  assign host_data_out = data_q;
endmodule
`default_nettype wire

//--- hw/scpm_map.svh
// Offsets, field positions, reset values and codes for the strap and pin mux block
`ifndef SCPM_MAP_SVH
`define SCPM_MAP_SVH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define SCPM_OFF_STRAP 8'h00
`define SCPM_OFF_PANEL 8'h04
`define SCPM_OFF_GPIO_DIR 8'h08
`define SCPM_OFF_GPIO_OUT 8'h0C
`define SCPM_OFF_GPIO_IN 8'h10
`define SCPM_OFF_PANEL_CTL 8'h14
// ****************************************
// Fields and reset values
// ****************************************
`define SCPM_INVERT_BIT 1
`define SCPM_PANEL_RESET 4'h0
`define SCPM_PANEL_CTL_RESET 8'h00
`define SCPM_GPIO_RESET 4'h0
// ****************************************
// Bus select codes
// ****************************************
`define SCPM_BUS_SYNC1 3'h0
`define SCPM_BUS_SYNC2 3'h1
`define SCPM_BUS_STROBE1 3'h3
`define SCPM_BUS_STROBE2 3'h5
`define SCPM_BUS_GENERIC 3'h7
`endif

//--- hw/scpm_pkg.sv
// Types shared by the strap and pin mux block
`default_nettype none
package scpm_pkg;
  // Host bus type decided at reset
  typedef enum logic [2:0] {
    SCPM_HOST_SYNC1 = 3'h0,
    SCPM_HOST_SYNC2 = 3'h1,
    SCPM_HOST_STROBE1 = 3'h2,
    SCPM_HOST_STROBE2 = 3'h3,
    SCPM_HOST_GENERIC1 = 3'h4,
    SCPM_HOST_GENERIC2 = 3'h5,
    SCPM_HOST_RESERVED = 3'h6
  } scpm_host_t;
  // Panel types
  typedef enum logic [3:0] {
    SCPM_PNL_MONO4 = 4'h0,
    SCPM_PNL_MONO8 = 4'h1,
    SCPM_PNL_MONO8D = 4'h2,
    SCPM_PNL_COL4 = 4'h3,
    SCPM_PNL_COL8F1 = 4'h4,
    SCPM_PNL_COL8F2 = 4'h5,
    SCPM_PNL_COL8D = 4'h6,
    SCPM_PNL_TFT9 = 4'h7,
    SCPM_PNL_TFT12 = 4'h8
  } scpm_panel_t;
  // Settings caught from the straps
  typedef struct packed {
    logic power_high;
    logic big_endian;
    scpm_host_t host;
  } scpm_cfg_t;
  // Host bus pins seen through the chosen mode
  typedef struct packed {
    logic [15:0] data;
    logic addr0;
    logic upper_byte_write;
    logic lower_byte_write;
    logic read_strobe;
    logic rd_wr;
    logic bus_start_input;
  } scpm_hostpins_t;
  // Decoded host strobes, active high
  typedef struct packed {
    logic lower_data_strobe;
    logic upper_data_strobe;
    logic byte_high_enable;
    logic read_low;
    logic read_high;
    logic write_low;
    logic write_high;
    logic [1:0] size;
    logic data_hi_lane;
  } scpm_strobes_t;
endpackage
`default_nettype wire

//--- hw/scpm_strap_latch.sv
// Captures the configuration straps once after reset release
`default_nettype none
`include "scpm_map.svh"
module scpm_strap_latch (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // Strap pins
  input wire logic power_polarity_strap_in,
  input wire logic byte_order_strap_in,
  input wire logic [2:0] bus_select_straps_in,
  input wire logic bus_start_input_in,
  // Caught settings
  output scpm_pkg::scpm_cfg_t cfg_out,
  output logic cfg_valid_out
);
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic [1:0] settle;
  logic done;
  scpm_pkg::scpm_host_t next_host;
  wire logic [2:0] sel;
  assign sel = sync2[3:1];
  // Two-flop synchroniser; straps are asynchronous pins
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
    end else begin
      sync1 <= {power_polarity_strap_in, byte_order_strap_in, bus_select_straps_in, bus_start_input_in};
      sync2 <= sync1;
    end
  end
  // Bus code decode; reserved codes fall to a safe idle mode
  always_comb begin
    next_host = scpm_pkg::SCPM_HOST_RESERVED;
    unique case (sel)
      `SCPM_BUS_SYNC1: next_host = scpm_pkg::SCPM_HOST_SYNC1;
      `SCPM_BUS_SYNC2: next_host = scpm_pkg::SCPM_HOST_SYNC2;
      `SCPM_BUS_STROBE1: next_host = scpm_pkg::SCPM_HOST_STROBE1;
      `SCPM_BUS_STROBE2: next_host = scpm_pkg::SCPM_HOST_STROBE2;
      `SCPM_BUS_GENERIC: next_host = sync2[0] ? scpm_pkg::SCPM_HOST_GENERIC2 : scpm_pkg::SCPM_HOST_GENERIC1;
      default: next_host = scpm_pkg::SCPM_HOST_RESERVED;
    endcase
  end
  // Latch once after the synchroniser has filled, then hold
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      settle <= 2'h0;
      done <= 1'b0;
      cfg_out <= '{power_high: 1'b0, big_endian: 1'b0, host: scpm_pkg::SCPM_HOST_RESERVED};
    end else if (!done) begin
      settle <= settle + 2'h1;
      if (settle == 2'h2) begin
        done <= 1'b1;
        cfg_out <= '{power_high: sync2[5], big_endian: sync2[4], host: next_host};
      end
    end
  end
  assign cfg_valid_out = done;
endmodule
`default_nettype wire

//--- hw/scpm_host_decode.sv
// Turns host bus pins into common strobes for the selected bus type
`default_nettype none
module scpm_host_decode (
  // Mode
  input wire scpm_pkg::scpm_host_t host_in,
  // Pins (active low strobes as on the bus)
  input wire scpm_pkg::scpm_hostpins_t pins_in,
  // Decoded strobes
  output scpm_pkg::scpm_strobes_t strobes_out
);
  // Pin roles per bus type
  always_comb begin
    strobes_out = '0;
    unique case (host_in)
      scpm_pkg::SCPM_HOST_SYNC1, scpm_pkg::SCPM_HOST_SYNC2: begin
        strobes_out.read_low = !pins_in.read_strobe;
        strobes_out.read_high = !pins_in.read_strobe;
        strobes_out.write_low = !pins_in.lower_byte_write;
        strobes_out.write_high = !pins_in.upper_byte_write;
      end
      scpm_pkg::SCPM_HOST_STROBE1: begin
        // Address bit zero pin carries the lower strobe; read and lower write are tied high
        strobes_out.lower_data_strobe = !pins_in.addr0;
        strobes_out.upper_data_strobe = !pins_in.upper_byte_write;
        strobes_out.read_low = pins_in.rd_wr && !pins_in.addr0;
        strobes_out.read_high = pins_in.rd_wr && !pins_in.upper_byte_write;
        strobes_out.write_low = !pins_in.rd_wr && !pins_in.addr0;
        strobes_out.write_high = !pins_in.rd_wr && !pins_in.upper_byte_write;
      end
      scpm_pkg::SCPM_HOST_STROBE2: begin
        // Single data strobe plus size bits; data lane is host D[31:16]
        strobes_out.upper_data_strobe = !pins_in.upper_byte_write;
        strobes_out.size = {pins_in.read_strobe, pins_in.lower_byte_write};
        strobes_out.data_hi_lane = 1'b1;
        strobes_out.read_low = pins_in.rd_wr && !pins_in.upper_byte_write;
        strobes_out.read_high = pins_in.rd_wr && !pins_in.upper_byte_write;
        strobes_out.write_low = !pins_in.rd_wr && !pins_in.upper_byte_write;
        strobes_out.write_high = !pins_in.rd_wr && !pins_in.upper_byte_write;
      end
      scpm_pkg::SCPM_HOST_GENERIC1: begin
        // Separate byte reads (rd/wr pin is high-byte read) and byte writes
        strobes_out.read_low = !pins_in.read_strobe;
        strobes_out.read_high = !pins_in.rd_wr;
        strobes_out.write_low = !pins_in.lower_byte_write;
        strobes_out.write_high = !pins_in.upper_byte_write;
      end
      scpm_pkg::SCPM_HOST_GENERIC2: begin
        // Byte-high enable gates the upper byte of one read and one write strobe
        strobes_out.byte_high_enable = !pins_in.upper_byte_write;
        strobes_out.read_low = !pins_in.read_strobe && !pins_in.addr0;
        strobes_out.read_high = !pins_in.read_strobe && !pins_in.upper_byte_write;
        strobes_out.write_low = !pins_in.lower_byte_write && !pins_in.addr0;
        strobes_out.write_high = !pins_in.lower_byte_write && !pins_in.upper_byte_write;
      end
      default: strobes_out = '0;
    endcase
  end
endmodule
`default_nettype wire

//--- sim/scpm_top_props.sv
// Concurrent checks on the ports of the strap and pin mux block
`default_nettype none
module scpm_top_chk (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // Straps and engine inputs
  input wire logic power_polarity_strap_in,
  input wire logic byte_order_strap_in,
  input wire logic [2:0] bus_select_straps_in,
  input wire logic bus_start_input_in,
  input wire scpm_pkg::scpm_hostpins_t host_pins_in,
  input wire logic panel_power_on_in,
  input wire logic frame_pulse_in,
  input wire logic shift_clock_in,
  input wire logic [3:0] panel_data_hi_in,
  // Block outputs
  input wire scpm_pkg::scpm_strobes_t host_strobes_out,
  input wire logic [15:0] host_data_out,
  input wire logic panel_power_control_out,
  input wire logic frame_pulse_out,
  input wire logic shift_clock_out,
  input wire logic [3:0] panel_data_hi_oe_n_out,
  input wire logic video_invert_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] since_rst;
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (!reset_n_in);
  // ****************************************
  // Cycles since release; at the top value the straps are surely caught
  // ****************************************
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      since_rst <= 4'h0;
    end else if (since_rst != 4'hF) begin
      since_rst <= since_rst + 4'h1;
    end
  end
  // Reset must leave the power pin off and every shared pin released
  chk_reset_quiet: assert property (@(posedge mclk_in) disable iff (1'h0)
    !reset_n_in |-> (!panel_power_control_out && panel_data_hi_oe_n_out == 4'hF))
    else $error("outputs active during reset");
  chk_power_level: assert property (since_rst == 4'hF |->
    panel_power_control_out == (power_polarity_strap_in ~^ $past(panel_power_on_in)))
    else $error("power pin level wrong for polarity");
  chk_data_swap: assert property (since_rst == 4'hF |-> host_data_out == (byte_order_strap_in ?
    {$past(host_pins_in.data[7:0], 3), $past(host_pins_in.data[15:8], 3)} : $past(host_pins_in.data, 3)))
    else $error("host data byte order wrong");
  chk_reserved_quiet: assert property (since_rst == 4'hF &&
    bus_select_straps_in inside {3'h2, 3'h4, 3'h6} |-> host_strobes_out == '0)
    else $error("strobes active on reserved bus code");
  chk_strobe_remap: assert property (since_rst == 4'hF && bus_select_straps_in == 3'h3 |->
    host_strobes_out.lower_data_strobe == !$past(host_pins_in.addr0, 2))
    else $error("lower data strobe not taken from address zero pin");
  chk_generic_write: assert property (since_rst == 4'hF && bus_select_straps_in == 3'h7 &&
    !bus_start_input_in |-> host_strobes_out.write_low == !$past(host_pins_in.lower_byte_write, 2))
    else $error("generic low byte write not decoded");
  chk_timing_pass: assert property (since_rst >= 4'h2 |->
    {frame_pulse_out, shift_clock_out} == $past({frame_pulse_in, shift_clock_in}))
    else $error("timing pins not passed through");
  // Sync depth is the designer's; six high cycles covers it with margin
  chk_invert_hold: assert property (panel_data_hi_in[3] [*6] |=> !video_invert_out)
    else $error("invert active while bit eleven high");
endmodule
bind scpm_top scpm_top_chk u_chk (.mclk_in, .reset_n_in, .power_polarity_strap_in, .byte_order_strap_in,
  .bus_select_straps_in, .bus_start_input_in, .host_pins_in, .panel_power_on_in, .frame_pulse_in,
  .shift_clock_in, .panel_data_hi_in, .host_strobes_out, .host_data_out, .panel_power_control_out,
  .frame_pulse_out, .shift_clock_out, .panel_data_hi_oe_n_out, .video_invert_out);
`default_nettype wire

//--- sim/scpm_panel_model.sv
// Board side of the shared panel data pins eight to eleven
`default_nettype none
module scpm_panel_model (
  // Pin as the block sees it
  input wire logic [3:0] pin_out_in,
  input wire logic [3:0] pin_oe_n_in,
  // Parts the board hangs on each pin
  input wire logic [3:0] ext_en_in,
  input wire logic [3:0] ext_val_in,
  output logic [3:0] pin_level_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Block wins while driving; else the board part; an unused pin sits at the I/O supply
  assign pin_level_out = (~pin_oe_n_in & pin_out_in) | (pin_oe_n_in & ~ext_en_in) |
    (pin_oe_n_in & ext_en_in & ext_val_in);
endmodule
`default_nettype wire

//--- sim/scpm_top_tb.sv
// Self-checking bench for the strap and pin mux block
`default_nettype none
module scpm_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_in = 1'h0;
  logic reset_n_in = 1'h1;
  logic pwr = 1'h0, be = 1'h0, bstart = 1'h0, on = 1'h0, fr = 1'h0, ln = 1'h0, sh = 1'h0;
  logic [2:0] code = 3'h0, ds = 3'h0;
  logic [11:0] pix = 12'h5A3;
  scpm_pkg::scpm_hostpins_t pins = '1;
  scpm_pkg::scpm_strobes_t strb;
  logic cyc = 1'h0, stb = 1'h0, we = 1'h0, rerr = 1'h0;
  logic [3:0] sel = 4'h0, ext_en = 4'h0, ext_val = 4'h0, hi_lvl, hi_out, oe_n;
  logic [7:0] adr = 8'h00, pdat;
  logic [31:0] wdat = 32'h0, rdat = 32'h0, dat_o;
  logic [15:0] hdat;
  logic inv, pwr_out, fr_out, ln_out, sh_out, de_out, ack, err;
  int miscompares = 0, check_count = 0;
  scpm_top dut (.mclk_in, .reset_n_in, .power_polarity_strap_in(pwr), .byte_order_strap_in(be),
    .bus_select_straps_in(code), .bus_start_input_in(bstart), .host_pins_in(pins), .host_strobes_out(strb),
    .host_data_out(hdat), .panel_power_on_in(on), .frame_pulse_in(fr), .line_pulse_in(ln), .shift_clock_in(sh),
    .second_shift_clock_in(ds[1]), .backplane_bias_in(ds[2]), .display_enable_in(ds[0]), .pixel_data_in(pix),
    .video_invert_out(inv), .panel_power_control_out(pwr_out), .frame_pulse_out(fr_out), .line_pulse_out(ln_out),
    .shift_clock_out(sh_out), .display_enable_pin_out(de_out), .panel_data_out(pdat), .panel_data_hi_out(hi_out),
    .panel_data_hi_in(hi_lvl), .panel_data_hi_oe_n_out(oe_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err));
  scpm_panel_model u_panel (.pin_out_in(hi_out), .pin_oe_n_in(oe_n), .ext_en_in(ext_en), .ext_val_in(ext_val),
    .pin_level_out(hi_lvl));
  // ****************************************
  // Shared helpers
  // ****************************************
  initial begin
    forever #50 mclk_in = ~mclk_in;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  // One classic cycle; held until ack or err, then a cycle idle before the next
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t = 0;
    @(posedge mclk_in);
    {cyc, stb, we, adr, sel, wdat} <= {2'h3, w, a, 4'hF, d};
    do begin
      @(posedge mclk_in);
      t++;
    end while (ack !== 1'h1 && err !== 1'h1 && t < 20);
    rdat = dat_o;
    rerr = err;
    {cyc, stb} <= 2'h0;
    if (t >= 20) miscompares++;
    @(posedge mclk_in);
  endtask
  // Straps are only changed while reset is held; the bench never straps reserved codes except here
  task automatic restart(input logic p, input logic b, input logic [2:0] c, input logic s);
    @(posedge mclk_in);
    {reset_n_in, pwr, be, code, bstart} <= {1'h0, p, b, c, s};
    tick(4);
    reset_n_in <= 1'h1;
    tick(8);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_straps();
    logic [3:0] codes [9] = '{4'h0, 4'h2, 4'h6, 4'hA, 4'hE, 4'hF, 4'h4, 4'h8, 4'hD};
    logic [2:0] exp;
    for (int i = 0; i < 9; i++) begin
      restart(i[0], i[1], codes[i][3:1], codes[i][0]);
      exp = i < 6 ? i[2:0] : 3'h6;
      wb(1'h0, 8'h00, 32'h0);
      check("strap status", rdat, {26'h0, i[0], i[1], exp, 1'h1});
      on <= 1'h1;
      pins <= {16'h12AB, 6'h13};
      tick(4);
      check("power on", pwr_out, i[0]);
      check("host data", hdat, i[1] ? 16'hAB12 : 16'h12AB);
      if (i == 2) check("lower strobe", strb.lower_data_strobe, 1'h1);
      if (i == 3) check("upper lane", strb.data_hi_lane, 1'h1);
      if (i == 4) check("low write", strb.write_low, 1'h1);
      if (i >= 6) check("no strobes", strb, 32'h0);
      on <= 1'h0;
      tick(3);
      check("power off", pwr_out, !i[0]);
    end
    $display("test straps done");
  endtask
  task automatic test_panel();
    logic [2:0] src;
    restart(1'h1, 1'h0, 3'h0, 1'h0);
    for (int k = 1; k < 6; k++) begin
      wb(1'h0, 8'(k * 4), 32'h0);
      if (k != 4) check("register reset", rdat, 32'h0);
    end
    for (int t = 0; t < 9; t++) begin
      wb(1'h1, 8'h04, 32'(t));
      src = t > 6 ? 3'h1 : (t == 4 ? 3'h2 : 3'h4);
      for (int p = 0; p < 8; p++) begin
        {ds, fr, ln, sh} <= {p[2:0], p[2:0]};
        tick(3);
        check("enable pin", de_out, |(p[2:0] & src));
        check("timing pins", {fr_out, ln_out, sh_out}, p[2:0]);
      end
      if (t == 0 || t == 3) check("narrow data", pdat, 8'h30);
      if (t inside {1, 2, 4, 5, 6}) check("byte data", pdat, 8'hA3);
    end
    wb(1'h1, 8'h04, 32'h9);
    wb(1'h0, 8'h04, 32'h0);
    check("panel type kept", rdat, 32'h8);
    wb(1'h0, 8'h40, 32'h0);
    check("unmapped error", rerr, 1'h1);
    $display("test panel done");
  endtask
  task automatic test_gpio();
    restart(1'h0, 1'h1, 3'h3, 1'h0);
    wb(1'h1, 8'h04, 32'h1);
    wb(1'h1, 8'h0C, 32'h5);
    wb(1'h1, 8'h08, 32'hF);
    tick(3);
    check("gpio drive", {oe_n, hi_out}, 8'h05);
    {ext_en, ext_val} <= 8'h32;
    wb(1'h1, 8'h08, 32'h0);
    tick(4);
    check("gpio released", oe_n, 4'hF);
    wb(1'h0, 8'h10, 32'h0);
    check("gpio in", rdat, 32'hE);
    wb(1'h1, 8'h04, 32'h8);
    tick(3);
    check("tft drives", oe_n, 4'h0);
    $display("test gpio done");
  endtask
  task automatic test_invert();
    restart(1'h1, 1'h1, 3'h7, 1'h1);
    wb(1'h1, 8'h04, 32'h1);
    wb(1'h1, 8'h08, 32'hF);
    wb(1'h1, 8'h14, 32'h2);
    {ext_en, ext_val} <= 8'h80;
    tick(6);
    check("invert on", inv, 1'h1);
    check("bit eleven input", oe_n, 4'h8);
    ext_val <= 4'h8;
    tick(6);
    check("invert idle", inv, 1'h0);
    ext_val <= 4'h0;
    wb(1'h1, 8'h14, 32'h0);
    tick(6);
    check("invert off", inv, 1'h0);
    $display("test invert done");
  endtask
  // ****************************************
  // Run control
  // ****************************************
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    // A real falling edge so every asynchronous reset acts before the first clock
    reset_n_in <= 1'h0;
    test_straps();
    test_panel();
    test_gpio();
    test_invert();
    finish_test();
  end
  // The whole run needs about six hundred cycles; over thirty times that means a hang
  initial begin
    tick(20000);
    miscompares++;
    finish_test();
  end
endmodule
`default_nettype wire
